// >>> include/fagp_pkg.sv
// Package with register map, field layouts and carrier types of the port block.
package fagp_pkg;

    // ********************************************************************
    // Geometry and address map
    // ********************************************************************
    localparam int FAGP_NUM_PORTS = 3;
    localparam int FAGP_PORT_W = 32;
    localparam logic [31:0] FAGP_LOCAL_BASE = 32'hf800_0000;
    localparam logic [31:0] FAGP_SYS_BASE = 32'h400f_f000;
    localparam logic [31:0] FAGP_PORT_STRIDE = 32'h0000_0040;
    localparam logic [31:0] FAGP_SPACE_SIZE = 32'h0000_1000;

    // ********************************************************************
    // Register offsets within one port
    // ********************************************************************
    localparam logic [5:0] FAGP_OFS_LATCH = 6'h00;
    localparam logic [5:0] FAGP_OFS_SET = 6'h04;
    localparam logic [5:0] FAGP_OFS_CLEAR = 6'h08;
    localparam logic [5:0] FAGP_OFS_TOGGLE = 6'h0c;
    localparam logic [5:0] FAGP_OFS_INPUT = 6'h10;
    localparam logic [5:0] FAGP_OFS_DIR = 6'h14;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [31:0] FAGP_RST_LATCH = 32'h0000_0000;
    localparam logic [31:0] FAGP_RST_DIR = 32'h0000_0000;
    localparam logic [31:0] FAGP_RST_INPUT = 32'h0000_0000;

    // Register selector decoded from an offset.
    typedef enum logic [2:0] {
        FAGP_SEL_LATCH = 3'b000,
        FAGP_SEL_SET = 3'b001,
        FAGP_SEL_CLEAR = 3'b010,
        FAGP_SEL_TOGGLE = 3'b011,
        FAGP_SEL_INPUT = 3'b100,
        FAGP_SEL_DIR = 3'b101,
        FAGP_SEL_NONE = 3'b111
    } fagp_sel_t;

    // Local alias answer state.
    typedef enum logic [1:0] {
        FAGP_ST_IDLE = 2'b00,
        FAGP_ST_ERR = 2'b01
    } fagp_state_t;

    // One bus request.
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fagp_req_t;

    // One bus answer.
    typedef struct packed {
        logic ready;
        logic err;
        logic [31:0] rdata;
    } fagp_rsp_t;

endpackage

// >>> hw/fagp_decode.sv
// Address decoder of one port space: port index, register and validity.
`timescale 1ns/1ps
module fagp_decode #(
    parameter int NUM_PORTS = 3
) (
    // Request address and space base
    input wire logic [31:0] addr,
    input wire logic [31:0] base,
    // Decoded result
    output logic inSpace,
    output logic hit,
    output logic [1:0] portIdx,
    output fagp_pkg::fagp_sel_t sel
);
    import fagp_pkg::*;

    logic [31:0] rel;

    // Maps an in-port offset to its register selector.
    function automatic fagp_sel_t ofs_to_sel(input logic [5:0] ofs);
        if (ofs == FAGP_OFS_LATCH) begin
            return FAGP_SEL_LATCH;
        end else if (ofs == FAGP_OFS_SET) begin
            return FAGP_SEL_SET;
        end else if (ofs == FAGP_OFS_CLEAR) begin
            return FAGP_SEL_CLEAR;
        end else if (ofs == FAGP_OFS_TOGGLE) begin
            return FAGP_SEL_TOGGLE;
        end else if (ofs == FAGP_OFS_INPUT) begin
            return FAGP_SEL_INPUT;
        end else if (ofs == FAGP_OFS_DIR) begin
            return FAGP_SEL_DIR;
        end else begin
            return FAGP_SEL_NONE;
        end
    endfunction

    // Ports sit at a 0x40 stride above the space base.
    always_comb begin
        rel = addr - base;
        inSpace = (rel < FAGP_SPACE_SIZE);
        portIdx = rel[7:6];
        sel = ofs_to_sel(rel[5:0]);
        hit = inSpace && (rel[31:8] == 24'h000000)
            && (32'(rel[7:6]) < NUM_PORTS) && (sel != FAGP_SEL_NONE);
    end

endmodule // fagp_decode

// >>> hw/fagp_sync.sv
// Two-flop synchroniser for a vector of pin levels.
`timescale 1ns/1ps
module fagp_sync #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // The first stage feeds only the second to limit metastability.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule // fagp_sync

// >>> hw/fagp_port.sv
// Top of the aliased port block: registers, two access paths, pin logic.
// Function
// - Unimplemented pins read zero in input register.
// - Non-digital pins read zero as input.
// - Input holds while port control disabled.
// - Direction zero input, one output.
// - Output pins drive the latch level.
// - Set register writes ones into latch.
// - Clear register writes zeros into latch.
// - Toggle register inverts selected latch bits.
// - Set, clear, toggle read back zero.
// - Unmapped alias access answers bus error.
// - Valid zero wait, error one wait.
// - Registers mirrored at local alias base.
// - Ports placed at stride 0x40.
// - System access stalls behind local access.
// - Writes accepted while port control disabled.
// - Compute mode: local only, inputs frozen.
// - Unimplemented pins read zero in latch.
// - Same registers on system bus too.
`timescale 1ns/1ps
module fagp_port #(
    parameter int NUM_PORTS = 3,
    parameter logic [95:0] PIN_IMPL = {3{32'hffff_ffff}}
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Processor-local alias port
    input wire fagp_pkg::fagp_req_t locReq,
    output fagp_pkg::fagp_rsp_t locRsp,
    // System bus port
    input wire fagp_pkg::fagp_req_t sysReq,
    output fagp_pkg::fagp_rsp_t sysRsp,
    // Pin control context
    input wire logic computeMode,
    input wire logic [NUM_PORTS-1:0] portCtrlEn,
    input wire logic [NUM_PORTS*32-1:0] pinDigital,
    input wire logic [NUM_PORTS*32-1:0] pinGpio,
    // Pins
    input wire logic [NUM_PORTS*32-1:0] pinIn,
    output logic [NUM_PORTS*32-1:0] pinOut,
    output logic [NUM_PORTS*32-1:0] pinOe
);
    import fagp_pkg::*;

    // ********************************************************************
    // Storage
    // ********************************************************************
    logic [31:0] latch_ff [NUM_PORTS];
    logic [31:0] dir_ff [NUM_PORTS];
    logic [31:0] inSample_ff [NUM_PORTS];
    logic [NUM_PORTS*32-1:0] pinSync;
    fagp_state_t state_ff;
    fagp_rsp_t locRsp_ff;
    fagp_rsp_t sysRsp_ff;
    logic sysErrPend_ff;

    // ********************************************************************
    // Decoding of both access paths
    // ********************************************************************
    logic locIn, locHit, sysIn, sysHit;
    logic [1:0] locPort, sysPort;
    fagp_sel_t locSel, sysSel;

    fagp_decode #(.NUM_PORTS(NUM_PORTS)) u_loc_dec (
        .addr(locReq.addr),
        .base(FAGP_LOCAL_BASE),
        .inSpace(locIn),
        .hit(locHit),
        .portIdx(locPort),
        .sel(locSel)
    );

    fagp_decode #(.NUM_PORTS(NUM_PORTS)) u_sys_dec (
        .addr(sysReq.addr),
        .base(FAGP_SYS_BASE),
        .inSpace(sysIn),
        .hit(sysHit),
        .portIdx(sysPort),
        .sel(sysSel)
    );

    fagp_sync #(.W(NUM_PORTS*32)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .din(pinIn),
        .dout(pinSync)
    );

    // ********************************************************************
    // Arbitration
    // ********************************************************************
    logic locGo, locWr, sysGo, sysWr, locErrGo;

    // Local accesses win; the system path waits while a local request is valid.
    // In compute mode the system path is closed, so it is simply held.
    always_comb begin
        locGo = locReq.valid && locHit && (state_ff == FAGP_ST_IDLE);
        // Addresses outside the 4 KB space belong to someone else: no answer.
        locErrGo = locReq.valid && locIn && !locHit
            && (state_ff == FAGP_ST_IDLE);
        locWr = locGo && locReq.write;
        sysGo = sysReq.valid && !locReq.valid && !computeMode
            && !sysRsp_ff.ready && !sysErrPend_ff && sysHit;
        sysWr = sysGo && sysReq.write;
    end

    // ********************************************************************
    // Per-port registers
    // ********************************************************************
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic [31:0] impl;
            logic [31:0] dig;
            logic [31:0] gpio;
            logic wrL, wrS;
            fagp_sel_t wsel;
            logic [31:0] wdat;

            assign impl = PIN_IMPL[p*32 +: 32];
            assign dig = pinDigital[p*32 +: 32];
            assign gpio = pinGpio[p*32 +: 32];

            // Pick the one write that lands on this port this cycle.
            always_comb begin
                wrL = locWr && (32'(locPort) == p);
                wrS = sysWr && (32'(sysPort) == p);
                wsel = wrL ? locSel : sysSel;
                wdat = wrL ? locReq.wdata : sysReq.wdata;
            end

            // Writes ignore portCtrlEn on purpose.
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    latch_ff[p] <= FAGP_RST_LATCH;
                    dir_ff[p] <= FAGP_RST_DIR;
                end else if (wrL || wrS) begin
                    case (wsel)
                        FAGP_SEL_LATCH: latch_ff[p] <= wdat;
                        FAGP_SEL_SET: latch_ff[p] <= latch_ff[p] | wdat;
                        FAGP_SEL_CLEAR: latch_ff[p] <= latch_ff[p] & ~wdat;
                        FAGP_SEL_TOGGLE: latch_ff[p] <= latch_ff[p] ^ wdat;
                        FAGP_SEL_DIR: dir_ff[p] <= wdat;
                        default: latch_ff[p] <= latch_ff[p];
                    endcase
                end
            end

            // Input sampling freezes with port control off or in compute mode.
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    inSample_ff[p] <= FAGP_RST_INPUT;
                end else if (portCtrlEn[p] && !computeMode) begin
                    inSample_ff[p] <= pinSync[p*32 +: 32] & dig & impl;
                end
            end

            // Pins drive only when GPIO function and direction is out.
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    pinOut[p*32 +: 32] <= '0;
                    pinOe[p*32 +: 32] <= '0;
                end else begin
                    pinOe[p*32 +: 32] <= gpio & dir_ff[p] & impl;
                    pinOut[p*32 +: 32] <= latch_ff[p] & impl;
                end
            end
        end
    endgenerate

    // ********************************************************************
    // Read data
    // ********************************************************************
    // Returns the read view of a register; write-only ones read zero.
    function automatic logic [31:0] read_reg(input fagp_sel_t s,
                                             input logic [1:0] pi);
        logic [31:0] v;
        logic [31:0] im;
        v = '0;
        im = PIN_IMPL[pi*32 +: 32];
        case (s)
            FAGP_SEL_LATCH: v = latch_ff[pi] & im;
            FAGP_SEL_INPUT: v = inSample_ff[pi];
            FAGP_SEL_DIR: v = dir_ff[pi];
            default: v = '0;
        endcase
        return v;
    endfunction

    // ********************************************************************
    // Local alias answer
    // ********************************************************************
    // A valid access answers in the cycle after it is taken; a bad one
    // spends one extra cycle in the error state before the answer.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= FAGP_ST_IDLE;
        end else begin
            case (state_ff)
                FAGP_ST_IDLE: if (locErrGo) state_ff <= FAGP_ST_ERR;
                FAGP_ST_ERR: state_ff <= FAGP_ST_IDLE;
                default: state_ff <= FAGP_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            locRsp_ff <= '0;
        end else begin
            locRsp_ff.ready <= locGo || (state_ff == FAGP_ST_ERR);
            locRsp_ff.err <= (state_ff == FAGP_ST_ERR);
            locRsp_ff.rdata <= (locGo && !locReq.write) ?
                read_reg(locSel, locPort) : 32'h0000_0000;
        end
    end

    // ********************************************************************
    // System bus answer
    // ********************************************************************
    // Unmapped system accesses also take an error; they wait for a free
    // cycle like valid ones so the local path keeps priority.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sysRsp_ff <= '0;
            sysErrPend_ff <= 1'b0;
        end else begin
            sysErrPend_ff <= sysReq.valid && sysIn && !sysHit && !locReq.valid
                && !computeMode && !sysRsp_ff.ready && !sysErrPend_ff;
            sysRsp_ff.ready <= sysGo || sysErrPend_ff;
            sysRsp_ff.err <= sysErrPend_ff;
            sysRsp_ff.rdata <= (sysGo && !sysReq.write) ?
                read_reg(sysSel, sysPort) : 32'h0000_0000;
        end
    end

    assign locRsp = locRsp_ff;
    assign sysRsp = sysRsp_ff;

endmodule // fagp_port

// >>> dv/fagp_master.sv
// Bus master model that drives one request port of the port block.
`timescale 1ns/1ps
module fagp_master
    import fagp_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request out, answer in
    output fagp_pkg::fagp_req_t req,
    input wire fagp_pkg::fagp_rsp_t rsp
);
    initial req = '0;
    // Hold the request until ready shows, then release it with inverted
    // fields so a stale address can never pass for a fresh one.
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(negedge clk);
        req <= '{1'b1, w, a, d};
        do begin
            @(negedge clk);
            n++;
        end while (rsp.ready !== 1'b1 && n < 20);
        q = rsp.rdata;
        e = rsp.err;
        // A request that never saw ready is a hang and counts as a mismatch.
        if (rsp.ready !== 1'b1) begin
            tb_fagp_port.err_count++;
        end
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule // fagp_master

// >>> dv/fagp_port_props.sv
// Checker of answer timing, read masking and pin enables of the port block.
`timescale 1ns/1ps
module fagp_port_props
    import fagp_pkg::*;
#(
    parameter int NUM_PORTS = 3,
    parameter logic [95:0] PIN_IMPL = {3{32'hffff_ffff}}
) (
    // Clock, reset and buses
    input wire logic clk,
    input wire logic rstn,
    input wire fagp_pkg::fagp_req_t locReq,
    input wire fagp_pkg::fagp_rsp_t locRsp,
    input wire fagp_pkg::fagp_req_t sysReq,
    input wire fagp_pkg::fagp_rsp_t sysRsp,
    // Context and pins
    input wire logic computeMode,
    input wire logic [NUM_PORTS*32-1:0] pinGpio,
    input wire logic [NUM_PORTS*32-1:0] pinOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic locHit, locIn, sysHit, woRd, maskRd;
    logic [1:0] portSel_ff;
    function automatic logic hit(logic [31:0] a, logic [31:0] b);
        return a[31:12] == b[31:12] && a[11:6] < NUM_PORTS &&
            a[5:0] inside {6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14};
    endfunction
    // Decode kept here so a decoder slip cannot hide itself.
    assign locIn = locReq.addr[31:12] == FAGP_LOCAL_BASE[31:12];
    assign locHit = hit(locReq.addr, FAGP_LOCAL_BASE);
    assign sysHit = hit(sysReq.addr, FAGP_SYS_BASE);
    assign woRd = locReq.valid && !locReq.write && locHit &&
        !locReq.addr[4] && locReq.addr[3:2] != 2'b00;
    assign maskRd = locReq.valid && !locReq.write && locHit &&
        locReq.addr[3:0] == 4'h0;
    // Port of the local request answered next.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            portSel_ff <= 2'h0;
        else
            portSel_ff <= locReq.addr[7:6];
    end
    a_loc_zero_wait: assert property (
        $rose(locReq.valid) && locHit |=> locRsp.ready && !locRsp.err)
        else $error("local hit not answered next cycle");
    a_loc_miss_err: assert property (
        $rose(locReq.valid) && locIn && !locHit
        |=> !locRsp.ready ##1 (locRsp.ready && locRsp.err))
        else $error("local miss not errored after one wait");
    a_sys_hit_wait: assert property (
        $rose(sysReq.valid) && sysHit && !locReq.valid && !computeMode
        |=> sysRsp.ready && !sysRsp.err)
        else $error("system hit not answered next cycle");
    a_sys_stall: assert property (
        (locReq.valid || computeMode) [*3] |-> !sysRsp.ready)
        else $error("system answered while blocked");
    a_wo_read_zero: assert property (
        $past(woRd) && locRsp.ready |-> locRsp.rdata == 32'h0)
        else $error("write-only register read nonzero");
    a_unbonded_zero: assert property (
        $past(maskRd) && locRsp.ready
        |-> (locRsp.rdata & ~PIN_IMPL[{portSel_ff, 5'h0} +: 32]) == 0)
        else $error("unbonded pin read nonzero");
    a_oe_needs_gpio: assert property (
        (pinOe & ~pinGpio & ~$past(pinGpio)) == 0)
        else $error("pin driven outside port function");
    a_rdata_idle: assert property (
        !locRsp.ready |-> locRsp.rdata == 32'h0)
        else $error("read data shown without ready");
    c_loc_err: cover property (locRsp.err);
    c_sys_block: cover property (computeMode && sysReq.valid);
    c_wo_read: cover property ($past(woRd) && locRsp.ready);
endmodule // fagp_port_props

bind fagp_port fagp_port_props #(.NUM_PORTS(NUM_PORTS),
    .PIN_IMPL(PIN_IMPL)) fagp_port_props_inst (.clk, .rstn, .locReq,
    .locRsp, .sysReq, .sysRsp, .computeMode, .pinGpio, .pinOe);

// >>> dv/tb_fagp_port.sv
// Self-checking bench of the aliased port block.
`timescale 1ns/1ps
module tb_fagp_port;
    import fagp_pkg::*;
    // Port 0 has only its low 24 pins bonded.
    localparam logic [95:0] IMPL = {64'hffff_ffff_ffff_ffff, 32'h00ff_ffff};
    logic clk, rstn, computeMode, e;
    logic [2:0] portCtrlEn;
    logic [95:0] pinDigital, pinGpio, pinIn, pinOut, pinOe;
    logic [31:0] q;
    fagp_req_t locReq, sysReq;
    fagp_rsp_t locRsp, sysRsp;
    int err_count = 0;
    int n_compared = 0;
    fagp_port #(.NUM_PORTS(3), .PIN_IMPL(IMPL)) fagp_port_inst (.clk,
        .rstn, .locReq, .locRsp, .sysReq, .sysRsp, .computeMode,
        .portCtrlEn, .pinDigital, .pinGpio, .pinIn, .pinOut, .pinOe);
    fagp_master fagp_master_inst (.clk, .req(locReq), .rsp(locRsp));
    fagp_master fagp_master_sys_inst (.clk, .req(sysReq), .rsp(sysRsp));
    // ****
    // Tasks
    // ****
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One access: s low takes the local path, s high the system path.
    task automatic acc(input bit s, input logic w, input logic [1:0] p,
        input logic [5:0] o, input logic [31:0] d);
        logic [31:0] a;
        a = (s ? FAGP_SYS_BASE : FAGP_LOCAL_BASE) | {24'h0, p, o};
        if (s)
            fagp_master_sys_inst.xfer(w, a, d, q, e);
        else
            fagp_master_inst.xfer(w, a, d, q, e);
    endtask
    task automatic rd(input bit s, input logic [1:0] p,
        input logic [5:0] o, input logic [31:0] x);
        acc(s, 1'b0, p, o, '0);
        check(q, x);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // The run needs about 130 cycles; five thousand means a hang.
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
    // Main sequence.
    initial begin
        rstn = 1'b0;
        computeMode = 1'b0;
        portCtrlEn = 3'h7;
        pinDigital = '1;
        pinGpio = '1;
        pinIn = '0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 18; i++)
            rd(1'b0, 2'(i / 6), 6'(i % 6 * 4), '0);
        acc(1'b0, 1'b1, 2'h1, FAGP_OFS_LATCH, 32'h1234_5678);
        acc(1'b0, 1'b1, 2'h1, FAGP_OFS_SET, 32'h0000_00f0);
        rd(1'b0, 2'h1, FAGP_OFS_LATCH, 32'h1234_56f8);
        acc(1'b0, 1'b1, 2'h1, FAGP_OFS_CLEAR, 32'h0000_0f00);
        rd(1'b0, 2'h1, FAGP_OFS_LATCH, 32'h1234_50f8);
        acc(1'b0, 1'b1, 2'h1, FAGP_OFS_TOGGLE, 32'hffff_0000);
        rd(1'b0, 2'h1, FAGP_OFS_LATCH, 32'hedcb_50f8);
        rd(1'b1, 2'h1, FAGP_OFS_LATCH, 32'hedcb_50f8);
        rd(1'b1, 2'h1, FAGP_OFS_SET, 32'h0);
        acc(1'b0, 1'b1, 2'h0, FAGP_OFS_LATCH, '1);
        rd(1'b0, 2'h0, FAGP_OFS_LATCH, 32'h00ff_ffff);
        acc(1'b0, 1'b1, 2'h1, FAGP_OFS_DIR, 32'h0000_ffff);
        pinGpio[39:32] = '0;
        repeat (2) @(negedge clk);
        check(pinOe[63:32], 32'h0000_ff00);
        check(pinOut[63:32] & pinOe[63:32], 32'h0000_5000);
        pinIn = {32'hcafe_f00d, 32'h0, 32'hffff_ffff};
        repeat (4) @(negedge clk);
        rd(1'b0, 2'h2, FAGP_OFS_INPUT, 32'hcafe_f00d);
        rd(1'b0, 2'h0, FAGP_OFS_INPUT, 32'h00ff_ffff);
        pinDigital[79:64] = '0;
        repeat (4) @(negedge clk);
        rd(1'b0, 2'h2, FAGP_OFS_INPUT, 32'hcafe_0000);
        portCtrlEn[2] = 1'b0;
        pinIn[95:64] = '0;
        repeat (4) @(negedge clk);
        rd(1'b0, 2'h2, FAGP_OFS_INPUT, 32'hcafe_0000);
        acc(1'b0, 1'b1, 2'h2, FAGP_OFS_LATCH, 32'h5a5a_5a5a);
        rd(1'b0, 2'h2, FAGP_OFS_LATCH, 32'h5a5a_5a5a);
        portCtrlEn[2] = 1'b1;
        repeat (4) @(negedge clk);
        rd(1'b0, 2'h2, FAGP_OFS_INPUT, 32'h0);
        acc(1'b0, 1'b0, 2'h0, 6'h18, '0);
        check({31'h0, e}, 32'h1);
        acc(1'b0, 1'b1, 2'h3, FAGP_OFS_LATCH, '1);
        check({31'h0, e}, 32'h1);
        acc(1'b1, 1'b0, 2'h0, 6'h3c, '0);
        check({31'h0, e}, 32'h1);
        fork
            acc(1'b0, 1'b1, 2'h0, FAGP_OFS_DIR, 32'h0000_0011);
            acc(1'b1, 1'b1, 2'h2, FAGP_OFS_DIR, 32'h0000_0022);
        join
        rd(1'b1, 2'h0, FAGP_OFS_DIR, 32'h0000_0011);
        rd(1'b0, 2'h2, FAGP_OFS_DIR, 32'h0000_0022);
        computeMode = 1'b1;
        pinIn[95:64] = '1;
        fork
            acc(1'b1, 1'b0, 2'h2, FAGP_OFS_LATCH, '0);
        join_none
        repeat (6) @(negedge clk);
        rd(1'b0, 2'h2, FAGP_OFS_INPUT, 32'h0);
        check({31'h0, sysReq.valid}, 32'h1);
        computeMode = 1'b0;
        wait fork;
        check(q, 32'h5a5a_5a5a);
        finish_test();
    end
endmodule // tb_fagp_port
